// ===== rtl/atd_defs.svh
// register offsets, field positions and the conversion length in clocks
`ifndef ATD_DEFS_SVH
`define ATD_DEFS_SVH
`define ATD_OFF_CTRL 12'h000
`define ATD_OFF_STAT 12'h004
`define ATD_OFF_RESULT 12'h008
`define ATD_OFF_IRQ_STAT 12'h00C
`define ATD_OFF_IRQ_EN 12'h010
`define ATD_OFF_IRQ_CLR 12'h014
`define ATD_OFF_DMA_ACK 12'h018
`define ATD_CTRL_ENC 0
`define ATD_CTRL_SC 1
`define ATD_CTRL_SRC_LO 2
`define ATD_CTRL_DMA_EN 4
`define ATD_CTRL_DMA_LVL 5
`define ATD_STAT_BUSY 0
`define ATD_STAT_STUCK 1
`define ATD_STAT_RDY 2
`define ATD_IRQ_DONE 0
`define ATD_IRQ_STUCK 1
`define ATD_CONV_CYCLES 16
`endif

// ===== rtl/atd_pkg.sv
// types shared by the trigger and handoff logic
package atd_pkg;
  typedef enum logic [1:0] {
    ATD_SRC_SOFT,
    ATD_SRC_TIMER_A,
    ATD_SRC_TIMER_B,
    ATD_SRC_EXT
  } atd_src_e;
  typedef enum {
    ATD_IDLE,
    ATD_CONVERT,
    ATD_HUNG
  } atd_state_e;
endpackage

// ===== rtl/atd_sync_if.sv
// carrier between the top and the trigger-pin synchroniser
`timescale 1ns/1ps
interface atd_sync_if;
  logic level;
  logic rise;
  modport src(output level, output rise);
  modport dst(input level, input rise);
endinterface

// ===== rtl/atd_sync.sv
// three-stage synchroniser with rising-edge detection for a trigger pin
`timescale 1ns/1ps
module atd_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous pin
  input wire logic pin,
  // synchronised result
  atd_sync_if.src sync
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic lvl_r;
  logic lvl_nxt;

  // shift, accept a change once the second and third stages agree
  always_comb begin
    sh_nxt = {sh_r[1:0], pin};
    lvl_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : lvl_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r <= 3'h0;
      lvl_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign sync.level = lvl_r;
  assign sync.rise = lvl_nxt & ~lvl_r;
endmodule

// ===== rtl/atd_top.sv
// converter trigger and result handoff logic with an APB register slave
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "atd_defs.svh"
// Summary of operation
// R1: after a processor-collected result, edge-mode dma requests are never raised (stuck).
// R2: software should not switch between processor and dma result collection.
// R3: power-on reset clears the stuck dma trigger state.
// R4: a dummy transfer acknowledged in level mode clears the stuck trigger state.
// R5: software discards the conversion and data of the recovery transfer.
// R6: enable and start set in one write after a hardware source hangs busy and start.
// R7: software sets enable and start in two writes after a hardware source.
// R8: start self-clears when conversion begins and busy falls when the result is done.
module atd_top
  import atd_pkg::*;
#(
  // conversion length in clocks and result width
  parameter int CONV_CYCLES = `ATD_CONV_CYCLES,
  parameter int RES_W = 12
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // hardware trigger pin
  input wire logic hw_trig,
  // converter core result
  input wire logic [RES_W-1:0] core_result,
  // dma request and interrupt
  output logic dma_req,
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  atd_sync_if trig_if();
  atd_state_e st_r, st_nxt;
  logic enc_r, enc_nxt; // conversion enable
  logic sc_r, sc_nxt; // start, self-clearing
  logic dma_en_r, dma_en_nxt; // results go to the dma controller
  logic lvl_r, lvl_nxt; // dma level select
  atd_src_e src_r, src_nxt;
  logic hw_used_r, hw_used_nxt;     // last trigger came from hardware
  logic cpu_took_r, cpu_took_nxt;   // last result collected by processor
  logic stuck_r, stuck_nxt;
  logic rdy_r, rdy_nxt;
  logic [RES_W-1:0] res_r, res_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [1:0] ist_r, ist_nxt; // sticky interrupt status
  logic [1:0] ien_r, ien_nxt; // interrupt enables
  logic dma_req_r, dma_req_nxt;
  logic irq_r, irq_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic wr, rd, done, start_ok;
  logic [1:0] ev; // done and done-while-stuck events
  logic ctrl_wr, irq_en_wr, irq_clr_wr, ack_wr, res_rd;

  // hardware trigger pin through three flops; rise marks an accepted edge
  atd_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(hw_trig),
    .sync(trig_if)
  );

  // address decode helper used for reads and writes
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // register map, one aligned word each:
  //   control: enable, start, source, dma enable, dma level select
  //   status: busy, trigger stuck, result ready (read only)
  //   result: last conversion; reading it marks processor collection
  //   irq status: done, done while stuck (read only, sticky)
  //   irq enable: same layout as irq status
  //   irq clear: write ones to clear; a same-cycle event wins
  //   dma ack: a finished dma transfer; in level mode it frees the trigger

  // ----------------------------------------------------------------
  // apb slave: answers in the access cycle after one wait
  // ----------------------------------------------------------------
  // pready_r masks the cycle in which pready stands, so an access that
  // the master still holds there is not taken a second time
  assign wr = psel & penable & pwrite & ~pready_r;
  assign rd = psel & penable & ~pwrite & ~pready_r;

  // one strobe per register access, shared by the state groups below
  assign ctrl_wr = wr & hit(paddr, `ATD_OFF_CTRL);
  assign irq_en_wr = wr & hit(paddr, `ATD_OFF_IRQ_EN);
  assign irq_clr_wr = wr & hit(paddr, `ATD_OFF_IRQ_CLR);
  assign ack_wr = wr & hit(paddr, `ATD_OFF_DMA_ACK);
  assign res_rd = rd & hit(paddr, `ATD_OFF_RESULT);

  always_comb begin
    pready_nxt = psel & penable & ~pready_r;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0;
    if (rd) begin
      if (hit(paddr, `ATD_OFF_CTRL))
        prdata_nxt = {26'h0, lvl_r, dma_en_r, src_r, sc_r, enc_r};
      else if (hit(paddr, `ATD_OFF_STAT))
        prdata_nxt = {29'h0, rdy_r, stuck_r, st_r != ATD_IDLE};
      else if (hit(paddr, `ATD_OFF_RESULT))
        prdata_nxt = 32'(res_r);
      else if (hit(paddr, `ATD_OFF_IRQ_STAT))
        prdata_nxt = {30'h0, ist_r};
      else if (hit(paddr, `ATD_OFF_IRQ_EN))
        prdata_nxt = {30'h0, ien_r};
      else if (!hit(paddr, `ATD_OFF_IRQ_CLR) && !hit(paddr, `ATD_OFF_DMA_ACK))
        pslverr_nxt = 1'b1;
    end
    if (wr && !(hit(paddr, `ATD_OFF_CTRL) || hit(paddr, `ATD_OFF_IRQ_EN) ||
        hit(paddr, `ATD_OFF_IRQ_CLR) || hit(paddr, `ATD_OFF_DMA_ACK)))
      pslverr_nxt = 1'b1;
  end

  // ----------------------------------------------------------------
  // trigger, conversion and handoff
  // ----------------------------------------------------------------
  // last counting cycle of a conversion
  assign done = (st_r == ATD_CONVERT) && (cnt_r == 16'(CONV_CYCLES - 1));

  always_comb begin
    st_nxt = st_r;
    enc_nxt = enc_r;
    sc_nxt = sc_r;
    src_nxt = src_r;
    dma_en_nxt = dma_en_r;
    lvl_nxt = lvl_r;
    hw_used_nxt = hw_used_r;
    cpu_took_nxt = cpu_took_r;
    stuck_nxt = stuck_r;
    rdy_nxt = rdy_r;
    res_nxt = res_r;
    cnt_nxt = (st_r == ATD_CONVERT) ? cnt_r + 16'h1 : 16'h0;
    dma_req_nxt = 1'b0;
    ev = 2'b00;
    start_ok = 1'b0;
    // control register write
    if (ctrl_wr) begin
      enc_nxt = pwdata[`ATD_CTRL_ENC];
      src_nxt = atd_src_e'(pwdata[`ATD_CTRL_SRC_LO+1:`ATD_CTRL_SRC_LO]);
      dma_en_nxt = pwdata[`ATD_CTRL_DMA_EN];
      lvl_nxt = pwdata[`ATD_CTRL_DMA_LVL];
      if (pwdata[`ATD_CTRL_SC])
        sc_nxt = 1'b1;
      // enable and start in one write after a hardware source hangs
      // until reset: start stays set and busy stays high
      if (pwdata[`ATD_CTRL_SC] && pwdata[`ATD_CTRL_ENC] && !enc_r && hw_used_r &&
          st_r == ATD_IDLE) begin
        st_nxt = ATD_HUNG; // R6
        sc_nxt = 1'b1; // R6
      end
      // switching to edge dma after processor collection wedges the trigger
      // the wedge outlives later writes; only a level-mode ack or reset frees it
      if (pwdata[`ATD_CTRL_DMA_EN] && !pwdata[`ATD_CTRL_DMA_LVL] && cpu_took_r)
        stuck_nxt = 1'b1; // R1
    end
    // start a conversion
    // a soft start reads start from an earlier cycle, so a single write of
    // enable and start begins one cycle after it lands
    if (st_r == ATD_IDLE && st_nxt == ATD_IDLE && enc_nxt) begin
      if (src_r == ATD_SRC_SOFT && sc_r)
        start_ok = 1'b1;
      else if (src_r != ATD_SRC_SOFT && trig_if.rise)
        start_ok = 1'b1;
    end
    if (start_ok) begin
      st_nxt = ATD_CONVERT;
      sc_nxt = 1'b0; // R8
      hw_used_nxt = (src_r != ATD_SRC_SOFT);
    end
    // result read by the processor
    if (res_rd) begin
      rdy_nxt = 1'b0;
      cpu_took_nxt = 1'b1;
    end
    // dma controller collects the result
    if (ack_wr) begin
      rdy_nxt = 1'b0;
      cpu_took_nxt = 1'b0;
      if (lvl_r)
        stuck_nxt = 1'b0; // R4
    end
    // conversion complete: busy falls, result latched; placed after the
    // collection clears so a fresh result wins over a same-cycle collection
    if (done) begin
      st_nxt = ATD_IDLE; // R8
      res_nxt = core_result;
      rdy_nxt = 1'b1;
      ev[`ATD_IRQ_DONE] = 1'b1;
      if (dma_en_r && !lvl_r && stuck_r)
        ev[`ATD_IRQ_STUCK] = 1'b1; // R1
    end
    // edge request once per result, level request while ready; no edge request when stuck
    if (dma_en_r) begin
      if (lvl_r)
        dma_req_nxt = rdy_nxt;
      else
        dma_req_nxt = done & ~stuck_nxt; // R1
    end
  end

  // ----------------------------------------------------------------
  // interrupts: set wins over clear
  // ----------------------------------------------------------------
  always_comb begin
    ist_nxt = ist_r;
    ien_nxt = ien_r;
    if (irq_clr_wr)
      ist_nxt = ist_r & ~pwdata[1:0];
    if (irq_en_wr)
      ien_nxt = pwdata[1:0];
    // events are or-ed in after the clear so a set in the same cycle wins
    ist_nxt = ist_nxt | ev;
    // level line, high while any enabled status bit is set
    irq_nxt = |(ist_nxt & ien_nxt);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // apb answer; every field is a one-cycle pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // trigger and handoff state; power-on reset clears the stuck trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ATD_IDLE;
      enc_r <= 1'b0;
      sc_r <= 1'b0;
      src_r <= ATD_SRC_SOFT;
      dma_en_r <= 1'b0;
      lvl_r <= 1'b0;
      hw_used_r <= 1'b0;
      cpu_took_r <= 1'b0;
      stuck_r <= 1'b0; // R3
      rdy_r <= 1'b0;
      res_r <= '0;
      cnt_r <= 16'h0;
      dma_req_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      enc_r <= enc_nxt;
      sc_r <= sc_nxt;
      src_r <= src_nxt;
      dma_en_r <= dma_en_nxt;
      lvl_r <= lvl_nxt;
      hw_used_r <= hw_used_nxt;
      cpu_took_r <= cpu_took_nxt;
      stuck_r <= stuck_nxt;
      rdy_r <= rdy_nxt;
      res_r <= res_nxt;
      cnt_r <= cnt_nxt;
      dma_req_r <= dma_req_nxt;
    end
  end

  // interrupt status, enables and line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= 2'h0;
      ien_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      ist_r <= ist_nxt;
      ien_r <= ien_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, each straight from a flip-flop
  // ----------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign dma_req = dma_req_r;
  assign irq = irq_r;
endmodule

// ===== tb/atd_top_asserts.sv
// checker on the ports of the trigger and handoff block
`timescale 1ns/1ps
module atd_top_asserts #(
  parameter int RES_W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // trigger, result, requests
  input wire logic hw_trig,
  input wire logic [RES_W-1:0] core_result,
  input wire logic dma_req,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_ok;
  logic lvl_r, lvl_nxt, cpu_r, cpu_nxt, stk_r, stk_nxt;
  // shadow of level mode and of the stuck edge-trigger condition
  assign wr_ok = psel && penable && pready && pwrite;
  always_comb begin
    lvl_nxt = (wr_ok && paddr == 12'h000) ? pwdata[5] : lvl_r;
    cpu_nxt = (psel && penable && pready && !pwrite && paddr == 12'h008) ? 1'b1 : cpu_r;
    stk_nxt = stk_r;
    if (wr_ok && paddr == 12'h000 && pwdata[4] && !pwdata[5] && cpu_r) stk_nxt = 1'b1;
    if (wr_ok && paddr == 12'h018 && lvl_r) begin
      stk_nxt = 1'b0;
      cpu_nxt = 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_r <= 1'b0;
      cpu_r <= 1'b0;
      stk_r <= 1'b0;
    end else begin
      lvl_r <= lvl_nxt;
      cpu_r <= cpu_nxt;
      stk_r <= stk_nxt;
    end
  end
  a_ready_one_wait: assert property (psel && $rose(penable) |=> pready) else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_ready_cause: assert property (pready |-> $past(psel) && $past(penable)) else $error("stray");
  a_err_unmapped: assert property (pready && paddr > 12'h018 |-> pslverr) else $error("no err");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("err without ready");
  a_reset_quiet: assert property ($rose(presetn) |-> !irq && !dma_req)
    else $error("busy out");
  a_dma_edge_pulse: assert property (dma_req && !lvl_r |=> !dma_req) else $error("long pulse");
  a_no_edge_stuck: assert property (stk_r && !lvl_r |-> !dma_req) else $error("stuck req");
  c_dma: cover property (dma_req);
  c_irq: cover property (irq);
  c_err: cover property (pslverr);
endmodule
bind atd_top atd_top_asserts #(.RES_W(RES_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .hw_trig(hw_trig),
  .core_result(core_result), .dma_req(dma_req), .irq(irq));

// ===== tb/atd_dma_model.sv
// dma controller stand-in that counts transfer requests
`timescale 1ns/1ps
module atd_dma_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request from the block
  input wire logic dma_req,
  // requests seen
  output int req_cnt
);
  logic last_r;
  // count rising requests; moved data is thrown away
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r <= 1'b0;
      req_cnt <= 0;
    end else begin
      last_r <= dma_req;
      if (dma_req && !last_r) req_cnt <= req_cnt + 1;
    end
  end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the trigger and handoff block
`timescale 1ns/1ps
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hw_trig = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, dma_req, irq;
  logic [11:0] core_result = 12'h000;
  logic [32:0] q[$];
  int mismatches = 0, cmp_count = 0, req_cnt, cyc = 0;
  always #12.5 pclk = ~pclk;
  atd_top #(.CONV_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hw_trig(hw_trig), .core_result(core_result),
    .dma_req(dma_req), .irq(irq));
  atd_dma_model u_dma (.pclk(pclk), .presetn(presetn), .dma_req(dma_req), .req_cnt(req_cnt));
  task chk(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // read monitor: compare each answer against the oldest note; also the timeout
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 5000) begin
      mismatches++;
      test_done();
    end
    // pre-edge values: the answer as it stands at the completing edge
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0)
      chk({pslverr, prdata}, q.pop_front());
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // pready is sampled at the rising edge that completes the transfer
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(0, a, 32'h0);
  endtask
  task wt();
    repeat (20) @(posedge pclk);
  endtask
  task hwconv(input logic [31:0] ctl);
    apb(1, 12'h000, ctl);
    @(posedge pclk) hw_trig <= 1;
    wt();
    hw_trig <= 0;
  endtask
  initial begin
    logic [11:0] res;
    void'($urandom(32'h4AE3));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(12'h004, 33'h0);
    rd(12'h030, 33'h1_0000_0000);
    apb(1, 12'h010, 32'h1);
    res = 12'($urandom);
    core_result <= res;
    apb(1, 12'h000, 32'h1);
    apb(1, 12'h000, 32'h3);
    wt();
    rd(12'h000, 33'h1);
    rd(12'h004, 33'h4);
    chk(irq, 1'b1);
    rd(12'h008, {21'h0, res});
    apb(1, 12'h014, 32'h3);
    @(negedge pclk) chk(irq, 1'b0);
    $display("soft conversion test done");
    apb(1, 12'h000, 32'h11);
    rd(12'h004, 33'h2);
    apb(1, 12'h000, 32'h13);
    wt();
    chk(req_cnt, 0);
    rd(12'h00C, 33'h3);
    apb(1, 12'h000, 32'h31);
    apb(1, 12'h018, 32'h0);
    rd(12'h004, 33'h0);
    apb(1, 12'h000, 32'h11);
    apb(1, 12'h000, 32'h13);
    wt();
    chk(req_cnt, 2);
    apb(1, 12'h018, 32'h0);
    $display("dma recovery test done");
    hwconv(32'h0000_0005);
    apb(1, 12'h000, 32'h0);
    apb(1, 12'h000, 32'h1);
    apb(1, 12'h000, 32'h3);
    wt();
    rd(12'h000, 33'h1);
    hwconv(32'h0000_000D);
    apb(1, 12'h000, 32'h0);
    apb(1, 12'h000, 32'h3);
    wt();
    rd(12'h000, 33'h3);
    rd(12'h004, 33'h5);
    @(posedge pclk) presetn <= 0;
    @(posedge pclk) presetn <= 1;
    rd(12'h000, 33'h0);
    $display("hang and reset test done");
    test_done();
  end
endmodule
